// >>> hdl/eeprom_access.sv
/*
  Data EEPROM access control: control, address and data registers on APB,
  self-timed writes counted on a calibrated RC oscillator, one-shot reads,
  processor stall, ready interrupt and sticky event interrupt.
  Assumes rc_osc is a free running oscillator asynchronous to clk and that
  por_b is released only by power-on, while rst_b covers every other reset.
*/
// Decided for this implementation: the APB interface to the registers.
// Overview of operation
// - control bits 7..4 ignore writes and read as zero.
// - ready interrupt held while global and ready enables set and write idle.
// - write starts only if arm bit already set when strobe is set.
// - hardware clears arm bit four clock cycles after software sets it.
// - write strobe stays set during write, cleared when write time ends.
// - setting write strobe stalls the processor two cycles.
// - read strobe fetches addressed byte into data register, self clearing.
// - setting read strobe stalls the processor four cycles.
// - during a write, read strobe and address register writes are ignored.
// - each write lasts 2048 calibrated RC oscillator cycles.
// - a write in progress completes across an rst_b reset, but not across por_b.
// - address register holds 10-bit byte address, upper bits read zero.
// - data register supplies write byte and receives read byte.
`timescale 1ns/1ps
module eeprom_access #(
    parameter int RC_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        por_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rc_osc,
    output logic             irq,
    output logic             ready_irq,
    output logic             cpu_stall
);

    // ********************************************************************
    // elaboration checks
    // ********************************************************************
    if (RC_CYCLES < 2 || RC_CYCLES > (1 << eeprom_access_pkg::RC_CNT_W))
    begin : g_rc_check
        $error("RC_CYCLES must lie between 2 and the counter range");
    end

    if (eeprom_access_pkg::ARM_WINDOW == 3'h0 || eeprom_access_pkg::WRITE_STALL == 3'h0
        || eeprom_access_pkg::READ_STALL == 3'h0)
    begin : g_count_check
        $error("arm window and stall counts must be nonzero");
    end

    // ********************************************************************
    // declarations
    // ********************************************************************
    eeprom_access_pkg::ctrl_state_s                 st;
    eeprom_access_pkg::ctrl_state_s                 next_st;
    eeprom_access_pkg::write_engine_s               en;
    eeprom_access_pkg::write_engine_s               next_en;
    eeprom_access_pkg::nv_mem_req_s                 mem_req;
    logic [eeprom_access_pkg::NV_DATA_W-1:0]        mem_rdata;
    logic                                           start_write;
    logic                                           access;
    logic                                           hit;
    logic [31:0]                                    rd_val;
    logic [7:0]                                     ctl_val;
    logic [eeprom_access_pkg::EVT_W-1:0]            evt_set;
    logic [eeprom_access_pkg::EVT_W-1:0]            evt_clr;
    logic                                           rc_rise;
    logic                                           write_finish;

    localparam logic [eeprom_access_pkg::RC_CNT_W-1:0] RC_LAST =
        eeprom_access_pkg::RC_CNT_W'(RC_CYCLES - 1);

    // ********************************************************************
    // array
    // ********************************************************************
    always_comb
    begin
        mem_req.we    = en.done;
        mem_req.re    = st.read_strobe;
        mem_req.addr  = en.done ? en.addr : st.nv_address;
        mem_req.wdata = en.data;
    end

    nv_byte_array #(
        .ADDR_W (eeprom_access_pkg::NV_ADDR_W),
        .DATA_W (eeprom_access_pkg::NV_DATA_W)
    ) u_array (
        .clk   (clk),
        .req   (mem_req),
        .rdata (mem_rdata)
    );

    // ********************************************************************
    // register read view
    // ********************************************************************
    always_comb
    begin
        ctl_val                                       = 8'h00;
        ctl_val[eeprom_access_pkg::CTL_READ_STROBE]   = st.read_strobe;
        ctl_val[eeprom_access_pkg::CTL_WRITE_STROBE]  = en.busy;
        ctl_val[eeprom_access_pkg::CTL_WRITE_ARM]     = st.write_arm;
        ctl_val[eeprom_access_pkg::CTL_READY_IRQ_EN]  = st.ready_irq_enable;
        rd_val = 32'h0000_0000;
        hit    = 1'b1;
        unique case (paddr)
            eeprom_access_pkg::CONTROL_OFS:      rd_val[7:0] = ctl_val;
            eeprom_access_pkg::ADDRESS_OFS:      rd_val[eeprom_access_pkg::NV_ADDR_W-1:0] = st.nv_address;
            eeprom_access_pkg::DATA_OFS:         rd_val[eeprom_access_pkg::NV_DATA_W-1:0] = st.nv_data;
            eeprom_access_pkg::EVENT_STATUS_OFS: rd_val[eeprom_access_pkg::EVT_W-1:0] = st.evt_status;
            eeprom_access_pkg::EVENT_CLEAR_OFS:  rd_val = 32'h0000_0000;
            eeprom_access_pkg::EVENT_ENABLE_OFS: rd_val[eeprom_access_pkg::EVT_W-1:0] = st.evt_enable;
            eeprom_access_pkg::CPU_STATUS_OFS:   rd_val[eeprom_access_pkg::CPU_GLOBAL_IRQ] = st.global_irq_en;
            default:                             hit = 1'b0;
        endcase
    end

    // ********************************************************************
    // write end detection
    // ********************************************************************
    // reads only engine state, so the control side can see the coming busy drop
    always_comb
    begin
        rc_rise      = en.rc_level & ~en.rc_prev;
        write_finish = en.busy & rc_rise & (en.rc_cnt == RC_LAST);
    end

    // ********************************************************************
    // control side
    // ********************************************************************
    always_comb
    begin
        next_st             = st;
        start_write         = 1'b0;
        evt_clr             = '0;
        evt_set             = '0;
        access              = psel & penable & st.pready;
        next_st.pready      = 1'b0;
        next_st.pslverr     = 1'b0;
        next_st.read_strobe = 1'b0;
        next_st.read_load   = st.read_strobe;

        if (st.stall_cnt != 3'h0)
        begin
            next_st.stall_cnt = st.stall_cnt - 3'h1;
        end

        // arm window runs down on its own
        if (st.arm_cnt != 3'h0)
        begin
            next_st.arm_cnt = st.arm_cnt - 3'h1;
            if (st.arm_cnt == 3'h1)
            begin
                next_st.write_arm = 1'b0;
            end
        end

        if (st.read_load)
        begin
            next_st.nv_data = mem_rdata;
            evt_set[eeprom_access_pkg::EVT_READ_DONE] = 1'b1;
        end
        evt_set[eeprom_access_pkg::EVT_WRITE_DONE] = en.done;

        if (access && pwrite)
        begin
            unique case (paddr)
                eeprom_access_pkg::CONTROL_OFS:
                begin
                    next_st.ready_irq_enable = pwdata[eeprom_access_pkg::CTL_READY_IRQ_EN];
                    if (pwdata[eeprom_access_pkg::CTL_WRITE_ARM])
                    begin
                        next_st.write_arm = 1'b1;
                        next_st.arm_cnt   = eeprom_access_pkg::ARM_WINDOW;
                    end
                    else
                    begin
                        next_st.write_arm = 1'b0;
                        next_st.arm_cnt   = 3'h0;
                    end
                    if (pwdata[eeprom_access_pkg::CTL_WRITE_STROBE] && st.write_arm && !en.busy)
                    begin
                        start_write       = 1'b1;
                        next_st.write_arm = 1'b0;
                        next_st.arm_cnt   = 3'h0;
                        next_st.stall_cnt = eeprom_access_pkg::WRITE_STALL;
                    end
                    else if (pwdata[eeprom_access_pkg::CTL_READ_STROBE] && !en.busy)
                    begin
                        next_st.read_strobe = 1'b1;
                        next_st.stall_cnt   = eeprom_access_pkg::READ_STALL;
                    end
                end
                eeprom_access_pkg::ADDRESS_OFS:
                begin
                    if (!en.busy)
                    begin
                        next_st.nv_address = pwdata[eeprom_access_pkg::NV_ADDR_W-1:0];
                    end
                end
                eeprom_access_pkg::DATA_OFS:
                    next_st.nv_data = pwdata[eeprom_access_pkg::NV_DATA_W-1:0];
                eeprom_access_pkg::EVENT_CLEAR_OFS:
                    evt_clr = pwdata[eeprom_access_pkg::EVT_W-1:0];
                eeprom_access_pkg::EVENT_ENABLE_OFS:
                    next_st.evt_enable = pwdata[eeprom_access_pkg::EVT_W-1:0];
                eeprom_access_pkg::CPU_STATUS_OFS:
                    next_st.global_irq_en = pwdata[eeprom_access_pkg::CPU_GLOBAL_IRQ];
                default:
                    next_st.pslverr = 1'b0;
            endcase
        end

        // a set in the same cycle as its clear wins
        next_st.evt_status = (st.evt_status & ~evt_clr) | evt_set;
        next_st.irq        = |(next_st.evt_status & next_st.evt_enable);
        next_st.ready_irq  = next_st.global_irq_en & next_st.ready_irq_enable
                           & ~(start_write | (en.busy & ~write_finish));
        next_st.cpu_stall  = (next_st.stall_cnt != 3'h0);

        // answer only once the processor stall has run out
        if (psel && penable && !st.pready && st.stall_cnt == 3'h0)
        begin
            next_st.pready  = 1'b1;
            next_st.prdata  = rd_val;
            next_st.pslverr = ~hit;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st            <= '0;
            st.nv_address <= eeprom_access_pkg::ADDRESS_RESET;
            st.nv_data    <= eeprom_access_pkg::DATA_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ********************************************************************
    // write engine, reset only at power-on so a write outlives rst_b
    // ********************************************************************
    always_comb
    begin
        next_en          = en;
        next_en.done     = 1'b0;
        next_en.rc_sync  = {en.rc_sync[1:0], rc_osc};
        next_en.rc_prev  = en.rc_level;
        if (en.rc_sync[1] == en.rc_sync[2])
        begin
            next_en.rc_level = en.rc_sync[2];
        end
        if (start_write)
        begin
            next_en.busy   = 1'b1;
            next_en.rc_cnt = '0;
            next_en.addr   = st.nv_address;
            next_en.data   = st.nv_data;
        end
        else if (en.busy && rc_rise)
        begin
            if (en.rc_cnt == RC_LAST)
            begin
                next_en.busy = 1'b0;
                next_en.done = 1'b1;
            end
            else
            begin
                next_en.rc_cnt = en.rc_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge por_b)
    begin
        if (!por_b)
        begin
            en <= '0;
        end
        else
        begin
            en <= next_en;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    always_comb
    begin
        prdata    = st.prdata;
        pready    = st.pready;
        pslverr   = st.pslverr;
        irq       = st.irq;
        ready_irq = st.ready_irq;
        cpu_stall = st.cpu_stall;
    end

endmodule // eeprom_access

// >>> hdl/eeprom_access_pkg.sv
/*
  Shared constants and carrier types for the byte-wide data EEPROM access block:
  register offsets, control bit positions, timing counts and the state structs.
  Assumes a 32-bit APB register bus with byte addresses in paddr[7:0].
*/
package eeprom_access_pkg;

    // ********************************************************************
    // sizes
    // ********************************************************************
    localparam int NV_ADDR_W = 10;
    localparam int NV_DATA_W = 8;
    localparam int APB_AW    = 8;
    localparam int APB_DW    = 32;
    localparam int EVT_W     = 2;

    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [APB_AW-1:0] CONTROL_OFS      = 8'h1c;
    localparam logic [APB_AW-1:0] ADDRESS_OFS      = 8'h20;
    localparam logic [APB_AW-1:0] DATA_OFS         = 8'h24;
    localparam logic [APB_AW-1:0] EVENT_STATUS_OFS = 8'h28;
    localparam logic [APB_AW-1:0] EVENT_CLEAR_OFS  = 8'h2c;
    localparam logic [APB_AW-1:0] EVENT_ENABLE_OFS = 8'h30;
    localparam logic [APB_AW-1:0] CPU_STATUS_OFS   = 8'h34;

    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int CTL_READ_STROBE  = 0;
    localparam int CTL_WRITE_STROBE = 1;
    localparam int CTL_WRITE_ARM    = 2;
    localparam int CTL_READY_IRQ_EN = 3;
    localparam int CPU_GLOBAL_IRQ   = 7;
    localparam int EVT_WRITE_DONE   = 0;
    localparam int EVT_READ_DONE    = 1;

    // ********************************************************************
    // reset values and timing counts
    // ********************************************************************
    localparam logic [NV_ADDR_W-1:0] ADDRESS_RESET   = 10'h000;
    localparam logic [NV_DATA_W-1:0] DATA_RESET      = 8'h00;
    localparam logic [2:0]           ARM_WINDOW      = 3'h4;
    localparam logic [2:0]           WRITE_STALL     = 3'h2;
    localparam logic [2:0]           READ_STALL      = 3'h4;
    localparam int                   WRITE_RC_CYCLES = 2048;
    localparam int                   RC_CNT_W        = 12;

    // ********************************************************************
    // carriers
    // ********************************************************************
    typedef struct packed {
        logic                 we;
        logic                 re;
        logic [NV_ADDR_W-1:0] addr;
        logic [NV_DATA_W-1:0] wdata;
    } nv_mem_req_s;

    typedef struct packed {
        logic                 pready;
        logic                 pslverr;
        logic [APB_DW-1:0]    prdata;
        logic                 ready_irq_enable;
        logic                 write_arm;
        logic [2:0]           arm_cnt;
        logic                 read_strobe;
        logic                 read_load;
        logic [NV_ADDR_W-1:0] nv_address;
        logic [NV_DATA_W-1:0] nv_data;
        logic [2:0]           stall_cnt;
        logic                 cpu_stall;
        logic                 global_irq_en;
        logic [EVT_W-1:0]     evt_status;
        logic [EVT_W-1:0]     evt_enable;
        logic                 irq;
        logic                 ready_irq;
    } ctrl_state_s;

    typedef struct packed {
        logic                 busy;
        logic                 done;
        logic [2:0]           rc_sync;
        logic                 rc_level;
        logic                 rc_prev;
        logic [RC_CNT_W-1:0]  rc_cnt;
        logic [NV_ADDR_W-1:0] addr;
        logic [NV_DATA_W-1:0] data;
    } write_engine_s;

endpackage

// >>> hdl/nv_byte_array.sv
/*
  Byte-wide nonvolatile array model as a synchronous memory.
  Assumes one request per clock; read data come out of a register one cycle after re.
*/
`timescale 1ns/1ps
module nv_byte_array #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    input  wire logic                             clk,
    input  wire eeprom_access_pkg::nv_mem_req_s   req,
    output logic [DATA_W-1:0]                     rdata
);

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    if (ADDR_W != eeprom_access_pkg::NV_ADDR_W || DATA_W != eeprom_access_pkg::NV_DATA_W)
    begin : g_width_check
        $error("nv_byte_array widths must match the request carrier");
    end

    always_ff @(posedge clk)
    begin
        if (req.we)
        begin
            cells[req.addr] <= req.wdata;
        end
        if (req.re)
        begin
            rdata <= cells[req.addr];
        end
    end

endmodule // nv_byte_array

// >>> bench/rc_osc_model.sv
/*
  Free running calibrated RC oscillator that times the array writes.
  Assumes the bench picks fast or slow rate through slow; unrelated to clk.
*/
`timescale 1ns/1ps
module rc_osc_model (
    input  wire logic slow,
    output logic      rc_osc
);
    // ********************************************************************
    // oscillator
    // ********************************************************************
    initial
    begin
        rc_osc = 1'b0;
        #7;
        forever
        begin
            #(slow ? 150 : 50);
            rc_osc = ~rc_osc;
        end
    end
endmodule // rc_osc_model

// >>> bench/eeprom_access_monitor.sv
/*
  Port level checker for eeprom_access.
  Assumes the APB master keeps the request stable until pready.
*/
`timescale 1ns/1ps
module eeprom_access_monitor (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ready_irq,
    input wire logic        cpu_stall
);
    // ********************************************************************
    // helpers
    // ********************************************************************
    wire logic acc    = pready && psel && penable;
    wire logic ctl_rd = acc && !pwrite && paddr == eeprom_access_pkg::CONTROL_OFS;
    wire logic ctl_wr = acc && pwrite && paddr == eeprom_access_pkg::CONTROL_OFS;
    wire logic mapped = paddr inside {[8'h1c:8'h34]} && paddr[1:0] == 2'b00;
    logic [2:0] arm_age;
    logic [2:0] stall_run;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arm_age   <= 3'h7;
            stall_run <= 3'h0;
        end
        else
        begin
            arm_age   <= (ctl_wr && pwdata[2]) ? 3'h0 : (arm_age == 3'h7 ? 3'h7 : arm_age + 3'h1);
            stall_run <= !cpu_stall ? 3'h0 : (stall_run == 3'h7 ? 3'h7 : stall_run + 3'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ********************************************************************
    // assertions
    // ********************************************************************
    a_ctl_reserved: assert property (ctl_rd |-> prdata[31:4] == 28'h000_0000)
        else $error("control upper bits not zero");
    a_addr_upper: assert property (acc && !pwrite && paddr == eeprom_access_pkg::ADDRESS_OFS
        |-> prdata[31:10] == 22'h00_0000)
        else $error("address upper bits not zero");
    a_ready_busy: assert property (ctl_rd && (prdata[1] || !prdata[3]) |-> !$past(ready_irq))
        else $error("ready request while busy or disabled");
    a_arm_window: assert property (ctl_rd && prdata[2] |-> arm_age <= 3'h5)
        else $error("arm bit outlived its window");
    a_stall_len: assert property (stall_run <= 3'h4)
        else $error("stall too long");
    a_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl_wr && (pwdata[0] || pwdata[1])))
        else $error("stall without strobe");
    a_read_stall: assert property ($rose(cpu_stall) && $past(ctl_wr && pwdata[0])
        |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall length wrong");
    a_write_stall: assert property ($rose(cpu_stall) && $past(ctl_wr && pwdata[1] && !pwdata[0])
        |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("write stall length wrong");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
endmodule // eeprom_access_monitor

bind eeprom_access eeprom_access_monitor eeprom_access_monitor_inst (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ready_irq(ready_irq),
    .cpu_stall(cpu_stall)
);

// >>> bench/tb_eeprom_access.sv
/*
  Self checking bench for eeprom_access with random addresses and data.
  Assumes RC_CYCLES shortened to 8 and the RC model in rc_osc_model.
*/
`timescale 1ns/1ps
module tb_eeprom_access;
    localparam int RC = 8;
    localparam logic [7:0] CTL = eeprom_access_pkg::CONTROL_OFS;
    localparam logic [7:0] ADR = eeprom_access_pkg::ADDRESS_OFS;
    localparam logic [7:0] DAT = eeprom_access_pkg::DATA_OFS;
    localparam logic [7:0] EST = eeprom_access_pkg::EVENT_STATUS_OFS;
    localparam logic [7:0] ECL = eeprom_access_pkg::EVENT_CLEAR_OFS;
    localparam logic [7:0] EEN = eeprom_access_pkg::EVENT_ENABLE_OFS;
    localparam logic [7:0] CPU = eeprom_access_pkg::CPU_STATUS_OFS;
    logic        clk, rst_b, por_b, psel, penable, pwrite, slow, e;
    logic        pready, pslverr, rc_osc, irq, ready_irq, cpu_stall;
    logic [7:0]  paddr, d;
    logic [9:0]  a;
    logic [31:0] pwdata, prdata, r, rw;
    int          fail_count, n_tests;
    time         t_go;

    eeprom_access #(.RC_CYCLES(RC)) eeprom_access_inst (.clk(clk), .rst_b(rst_b), .por_b(por_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_osc(rc_osc), .irq(irq),
        .ready_irq(ready_irq), .cpu_stall(cpu_stall));
    rc_osc_model rc_osc_model_inst (.slow(slow), .rc_osc(rc_osc));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ********************************************************************
    // tasks
    // ********************************************************************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk("pready", 1, 0);
            end_sim;
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] ex, input string nm);
        apb(1'b0, ad, 32'h0000_0000);
        chk(nm, ex, r);
    endtask
    task automatic nv_write(input logic [9:0] ad, input logic [7:0] dt);
        wr(ADR, {22'h00_0000, ad});
        wr(DAT, {24'h00_0000, dt});
        wr(CPU, 32'h0000_0000);
        wr(CTL, 32'h0000_000C);
        wr(CTL, 32'h0000_000A);
        t_go = $time;
        wr(CPU, 32'h0000_0080);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 300; k++)
        begin
            apb(1'b0, CTL, 32'h0000_0000);
            if (r[1] === 1'b0)
                break;
        end
        chk("write end", 0, r[1]);
        if (r[1] !== 1'b0)
            end_sim;
        chk("write time", 1, ($time - t_go) / 25 >= (RC - 1) * (slow ? 12 : 4));
    endtask
    // ********************************************************************
    // main sequence
    // ********************************************************************
    initial
    begin
        {rst_b, por_b, psel, penable, pwrite, slow, paddr, pwdata} = '0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'h7102));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        rdchk(CTL, 32'h0000_0000, "control");
        rdchk(EST, 32'h0000_0000, "status");
        wr(CTL, 32'hFFFF_FFF8);
        rdchk(CTL, 32'h0000_0008, "control");
        wr(CPU, 32'h0000_0080);
        repeat (2) @(posedge clk);
        chk("ready_irq", 1, ready_irq);
        wr(CTL, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("ready_irq", 0, ready_irq);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("slverr", 1, e);
        chk("unmapped", 0, r);
        for (int i = 0; i < 3; i++)
        begin
            rw = $urandom;
            a = rw[9:0];
            d = 8'($urandom);
            wr(ADR, rw);
            rdchk(ADR, {22'h00_0000, a}, "address");
            wr(EEN, {31'h0000_0000, i != 1});
            nv_write(a, d);
            rdchk(CTL, 32'h0000_000A, "busy");
            chk("ready_irq", 0, ready_irq);
            wr(ADR, {22'h00_0000, ~a});
            wr(DAT, {24'h00_0000, ~d});
            wr(CTL, 32'h0000_0009);
            rdchk(ADR, {22'h00_0000, a}, "address");
            rdchk(DAT, {24'h00_0000, ~d}, "data");
            wait_idle;
            chk("ready_irq", 1, ready_irq);
            chk("irq", i != 1, irq);
            apb(1'b0, EST, 32'h0000_0000);
            chk("write done", 1, r[0]);
            wr(ECL, 32'h0000_0003);
            repeat (2) @(posedge clk);
            chk("irq", 0, irq);
            wr(CTL, 32'h0000_0009);
            rdchk(DAT, {24'h00_0000, d}, "data");
            rdchk(CTL, 32'h0000_0008, "control");
        end
        wr(CTL, 32'h0000_0002);
        rdchk(CTL, 32'h0000_0000, "no arm");
        wr(CTL, 32'h0000_0004);
        rdchk(CTL, 32'h0000_0004, "armed");
        repeat (3) @(posedge clk);
        wr(CTL, 32'h0000_0002);
        rdchk(CTL, 32'h0000_0000, "late strobe");
        slow <= 1'b1;
        a = 10'($urandom);
        d = 8'($urandom);
        nv_write(a, d);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(CTL, 32'h0000_0002, "busy");
        wait_idle;
        wr(ADR, {22'h00_0000, a});
        wr(CTL, 32'h0000_0001);
        rdchk(DAT, {24'h00_0000, d}, "data");
        end_sim;
    end
endmodule // tb_eeprom_access
